// ---- rtl/sbsram_core.sv ----
`timescale 1ns/100ps
// How it works
// R1: high mode pin: interleaved xor burst order
// R2: low mode pin: linear increment, wrap four
// R3: deselect on disabled chip, outputs off
// R4: processor strobe with select starts read
// R5: controller strobe starts read or write
// R6: no strobe, advance low steps counter
// R7: no strobe, advance high holds address
// R8: read data driven only while enable low
// R9: global or per-lane byte write gating
// R10: narrow variant uses two lanes only
// R11: host writes in wait cycle after processor start
// R12: host releases output enable before writing
// R13: sleep entered and left in two cycles; the code takes three edges from the pin (two to synchronise, one for sleep_r)
// R14: access in progress at sleep dropped
// R15: host deselects around sleep, two-cycle recovery
// R16: data outputs off during power-up
// R17: mode pin is static burst select
module sbsram_core #(
    parameter int ADDR_W = sbsram_pkg::SBSRAM_ADDR_W,
    parameter int LANES = sbsram_pkg::SBSRAM_LANES,
    parameter int LANE_W = sbsram_pkg::SBSRAM_LANE_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic chip_enable_n,
    input wire logic secondary_chip_enable,
    input wire logic third_chip_enable_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [LANES-1:0] lane_write_n,
    input wire logic output_enable_n,
    input wire logic burst_mode,
    input wire logic sleep_request,
    input wire logic [LANES*LANE_W-1:0] dataIn,
    output logic [LANES*LANE_W-1:0] dataOut,
    output logic [LANES-1:0] dataOe,
    output logic sleeping
);
    import sbsram_pkg::*;
    if (LANES != SBSRAM_LANES && LANES != SBSRAM_NARROW_LANES) begin : g_bad_lanes
        $error("lanes must be 4 or 2");
    end
    if (ADDR_W < 3) begin : g_bad_addr
        $error("address too narrow");
    end
    localparam int DW = LANES * LANE_W;
    sbsram_burst_if bif ();
    sbsram_burst_counter u_cnt (.clk(clk), .resetn(resetn), .bus(bif));

    // synchronisers for the asynchronous and static pins
    logic [1:0] sleepSync_r;
    logic [1:0] modeSync_r;
    logic [1:0] sleepCnt_r, sleepCnt_nxt;
    logic sleep_r, sleep_nxt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleepSync_r <= 2'h0;
            modeSync_r <= 2'h3;
        end else begin
            sleepSync_r <= {sleepSync_r[0], sleep_request};
            modeSync_r <= {modeSync_r[0], burst_mode};
        end
    end
    wire sleepIn = sleepSync_r[1];
    // sleep entry and exit each take three edges after the pin flips: two to synchronise, one to update sleep_r
    always_comb begin
        sleep_nxt = sleep_r;
        sleepCnt_nxt = 2'h0;
        if (sleepIn != sleep_r) begin
            sleepCnt_nxt = sleepCnt_r + 2'h1;
            if (sleepCnt_r == 2'(SBSRAM_SLEEP_CYC - 2)) begin
                sleep_nxt = sleepIn; // R13
                sleepCnt_nxt = 2'h0;
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_r <= 1'b0;
            sleepCnt_r <= 2'h0;
        end else begin
            sleep_r <= sleep_nxt;
            sleepCnt_r <= sleepCnt_nxt;
        end
    end
    assign sleeping = sleep_r;

    // cycle decode
    wire selected = !chip_enable_n && secondary_chip_enable && !third_chip_enable_n;
    logic [LANES-1:0] laneWr;
    logic writeReq;
    always_comb begin
        for (int i = 0; i < LANES; i++)
            laneWr[i] = !global_write_n || (!byte_write_gate_n && !lane_write_n[i]); // R9 R10
        writeReq = |laneWr; // R10
    end
    sbsram_cyc_e cyc_r, cyc_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic startNew, stepOn, deselect;
    always_comb begin
        cyc_nxt = cyc_r;
        addr_nxt = addr_r;
        startNew = 1'b0;
        stepOn = 1'b0;
        deselect = 1'b0;
        if (sleep_r || sleepIn) begin
            cyc_nxt = SBSRAM_IDLE; // R14
        end else if ((chip_enable_n && !controller_addr_strobe_n) ||
                     (!selected && !chip_enable_n &&
                      (!processor_addr_strobe_n || !controller_addr_strobe_n))) begin
            deselect = 1'b1;
            cyc_nxt = SBSRAM_IDLE; // R3
        end else if (!processor_addr_strobe_n && selected) begin
            startNew = 1'b1;
            addr_nxt = address;
            cyc_nxt = SBSRAM_RD; // R4
        end else if (!controller_addr_strobe_n && selected) begin
            startNew = 1'b1;
            addr_nxt = address;
            cyc_nxt = writeReq ? SBSRAM_WR : SBSRAM_RD; // R5
        end else if (cyc_r != SBSRAM_IDLE) begin
            stepOn = !burst_advance_n; // R6 R7
            cyc_nxt = writeReq ? SBSRAM_WR : SBSRAM_RD; // R11
        end
    end
    assign bif.load = startNew;
    assign bif.advance = stepOn;
    assign bif.baseLow = address[1:0];
    assign bif.linearOrder = !modeSync_r[1]; // R17
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_r <= SBSRAM_IDLE;
            addr_r <= '0;
        end else begin
            cyc_r <= cyc_nxt;
            addr_r <= addr_nxt;
        end
    end
    wire [ADDR_W-1:0] curAddr = {addr_r[ADDR_W-1:2], bif.curLow};

    // array write and registered read data
    logic [LANES-1:0] wrLanes_r;
    logic [DW-1:0] rdData_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrLanes_r <= '0;
        end else begin
            wrLanes_r <= laneWr;
        end
    end
    wire [DW-1:0] rdWord;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // per-lane array keeps one writer each
            logic [LANE_W-1:0] laneMem [0:(1<<ADDR_W)-1];
            always_ff @(posedge clk) begin
                if (cyc_r == SBSRAM_WR && wrLanes_r[g] && !sleep_r)
                    laneMem[curAddr] <= dataIn[g*LANE_W +: LANE_W]; // R9
            end
            assign rdWord[g*LANE_W +: LANE_W] = laneMem[curAddr];
        end
    endgenerate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= rdWord;
        end
    end
    assign dataOut = (cyc_r == SBSRAM_RD) ? rdWord : rdData_r;
    // output enable is asynchronous: used directly
    assign dataOe = {LANES{cyc_r == SBSRAM_RD && !output_enable_n && !sleep_r}}; // R8 R16

    sequence s_sleep_rise;
        $rose(sleepIn) && !sleep_r ##1 sleepIn;
    endsequence
    a_sleep_entry: assert property (@(posedge clk) disable iff (!resetn) // R13
        s_sleep_rise |=> sleep_r)
        else $error("sleep not entered in two cycles");
    a_read_drive: assert property (@(posedge clk) disable iff (!resetn) // R8
        |dataOe |-> cyc_r == SBSRAM_RD && !output_enable_n)
        else $error("data driven outside read");
    a_oe_release: assert property (@(posedge clk) disable iff (!resetn) // R8
        output_enable_n |-> dataOe == '0)
        else $error("data driven with output enable high");
    a_proc_read: assert property (@(posedge clk) disable iff (!resetn) // R4
        !sleep_r && !sleepIn && !processor_addr_strobe_n && selected |=> cyc_r == SBSRAM_RD)
        else $error("processor strobe did not start read");
    a_ctrl_write: assert property (@(posedge clk) disable iff (!resetn) // R5
        !sleep_r && !sleepIn && processor_addr_strobe_n && !controller_addr_strobe_n
        && selected && !global_write_n |=> cyc_r == SBSRAM_WR)
        else $error("controller strobe did not start write");
    a_deselect_idle: assert property (@(posedge clk) disable iff (!resetn) // R3
        chip_enable_n && !controller_addr_strobe_n |=> cyc_r == SBSRAM_IDLE && dataOe == '0)
        else $error("deselect did not idle");
    a_hold_wait: assert property (@(posedge clk) disable iff (!resetn) // R7
        cyc_r != SBSRAM_IDLE && !deselect && !startNew && burst_advance_n && !sleepIn
        && !sleep_r |=> $stable(bif.curLow))
        else $error("wait cycle moved address");
    a_step_adv: assert property (@(posedge clk) disable iff (!resetn) // R6
        stepOn && !$changed(modeSync_r[1]) |=> bif.curLow != $past(bif.curLow))
        else $error("advance did not step");
    a_sleep_drop: assert property (@(posedge clk) disable iff (!resetn) // R14
        sleep_r |=> cyc_r == SBSRAM_IDLE)
        else $error("access kept in sleep");
    sequence s_sleep_fall;
        $fell(sleepIn) && sleep_r ##1 !sleepIn;
    endsequence
    a_sleep_exit: assert property (@(posedge clk) disable iff (!resetn) // R13
        s_sleep_fall |=> !sleep_r)
        else $error("sleep not left in two cycles");
    a_sleep_quiet: assert property (@(posedge clk) disable iff (!resetn) // R14
        sleep_r |-> dataOe == '0)
        else $error("data driven in sleep");
    a_load_base: assert property (@(posedge clk) disable iff (!resetn) // R4 R5
        startNew |=> bif.curLow == $past(address[1:0]))
        else $error("burst did not start at external address");
    a_linear_step: assert property (@(posedge clk) disable iff (!resetn) // R2
        stepOn && bif.linearOrder |=> bif.curLow == 2'($past(bif.curLow) + 2'h1))
        else $error("linear burst did not increment");
endmodule

// ---- rtl/sbsram_pkg.sv ----
package sbsram_pkg;
    localparam int SBSRAM_ADDR_W = 18;
    localparam int SBSRAM_LANES = 4;
    localparam int SBSRAM_LANE_W = 9;
    localparam int SBSRAM_NARROW_LANES = 2;
    localparam int SBSRAM_SLEEP_CYC = 2;
    localparam int SBSRAM_CLK_NS = 100;
    localparam int SBSRAM_SLEEP_ENTRY_NS = 2 * SBSRAM_CLK_NS;
    localparam int SBSRAM_SLEEP_RECOVERY_NS = 2 * SBSRAM_CLK_NS;
    localparam logic [1:0] SBSRAM_OFS_ZERO = 2'h0;
    localparam logic [1:0] SBSRAM_STEP = 2'h1;
    typedef enum logic [1:0] {SBSRAM_IDLE, SBSRAM_RD, SBSRAM_WR} sbsram_cyc_e;
endpackage

// ---- rtl/sbsram_burst_if.sv ----
`timescale 1ns/100ps
interface sbsram_burst_if;
    logic load;
    logic advance;
    logic linearOrder;
    logic [1:0] baseLow;
    logic [1:0] curLow;
    modport ctrl (output load, output advance, output linearOrder, output baseLow, input curLow);
    modport cnt (input load, input advance, input linearOrder, input baseLow, output curLow);
endinterface

// ---- rtl/sbsram_burst_counter.sv ----
`timescale 1ns/100ps
module sbsram_burst_counter (
    input wire logic clk,
    input wire logic resetn,
    sbsram_burst_if.cnt bus
);
    import sbsram_pkg::*;
    logic [1:0] count_r;
    logic [1:0] count_nxt;
    logic [1:0] base_r;
    logic [1:0] base_nxt;
    always_comb begin
        count_nxt = count_r;
        base_nxt = base_r;
        if (bus.load) begin
            count_nxt = SBSRAM_OFS_ZERO;
            base_nxt = bus.baseLow;
        end else if (bus.advance) begin
            count_nxt = count_r + SBSRAM_STEP;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= SBSRAM_OFS_ZERO;
            base_r <= SBSRAM_OFS_ZERO;
        end else begin
            count_r <= count_nxt;
            base_r <= base_nxt;
        end
    end
    // linear adds and wraps in four, interleaved xors
    assign bus.curLow = bus.linearOrder ? base_r + count_r : base_r ^ count_r; // R1 R2
endmodule

// ---- testbench/sbsram_host_model.sv ----
`timescale 1ns/100ps
module sbsram_host_model #(
    parameter int LANES = 4,
    parameter int LW = 9
) (
    input wire logic clk,
    input wire logic hostDrive,
    input wire logic [LANES*LW-1:0] hostData,
    input wire logic [LANES*LW-1:0] dataOut,
    input wire logic [LANES-1:0] dataOe,
    output logic [LANES*LW-1:0] dataIn
);
    logic [LANES*LW-1:0] lastBus_r;
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            if (dataOe[i]) begin
                dataIn[i*LW+:LW] = dataOut[i*LW+:LW];
            end else if (hostDrive) begin
                dataIn[i*LW+:LW] = hostData[i*LW+:LW];
            end else begin
                dataIn[i*LW+:LW] = ~lastBus_r[i*LW+:LW];
            end
        end
    end
    always_ff @(posedge clk) begin
        lastBus_r <= dataIn;
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import sbsram_pkg::*;
    localparam int DW = SBSRAM_LANES * SBSRAM_LANE_W;
    logic clk = 0, resetn = 0, ceN = 1, ce2 = 1, pN = 1, cN = 0, advN = 1, gwN = 1;
    logic bweN = 1, oeN = 0, mode = 1, sleepReq = 0, drv = 0, slp, ce3N = 0;
    logic [SBSRAM_ADDR_W-1:0] addr = '0;
    logic [SBSRAM_LANES-1:0] laneN = '1, dOe;
    logic [DW-1:0] hData = '0, dIn, dOut;
    int errorCnt = 0, comparisons = 0;
    always #50 clk = ~clk;
    sbsram_core u_dut (.clk(clk), .resetn(resetn), .address(addr), .chip_enable_n(ceN),
        .secondary_chip_enable(ce2), .third_chip_enable_n(ce3N),
        .processor_addr_strobe_n(pN), .controller_addr_strobe_n(cN), .burst_advance_n(advN),
        .global_write_n(gwN), .byte_write_gate_n(bweN), .lane_write_n(laneN),
        .output_enable_n(oeN), .burst_mode(mode), .sleep_request(sleepReq), .dataIn(dIn),
        .dataOut(dOut), .dataOe(dOe), .sleeping(slp));
    sbsram_host_model #(.LANES(SBSRAM_LANES), .LW(SBSRAM_LANE_W)) u_host (.clk(clk),
        .hostDrive(drv), .hostData(hData), .dataOut(dOut), .dataOe(dOe), .dataIn(dIn));
    task automatic complete_run;
        if (errorCnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkF(input logic [3:0] got, input logic [3:0] exp);
        chk({32'h0, got}, {32'h0, exp});
    endtask
    function automatic logic [DW-1:0] pat(input logic m, input logic [1:0] b, input logic [1:0] n);
        return 36'h5A3C0F1E0 ^ {31'h0, m, b, n};
    endfunction
    task automatic drive(input logic c, input logic p, input logic s, input logic a, input logic w);
        @(negedge clk);
        ceN = c;
        pN = p;
        cN = s;
        advN = a;
        gwN = w;
    endtask
    task automatic rd(input logic [SBSRAM_ADDR_W-1:0] a, input logic [DW-1:0] e);
        addr = a;
        drive(0, 0, 1, 1, 0);
        drive(1, 1, 0, 1, 1);
        chk(dOut, e);
        chkF(dOe, 4'hF);
    endtask
    task automatic burstOrder(input logic m, input logic [1:0] b);
        logic [1:0] lo;
        mode = m;
        repeat (3) @(negedge clk);
        addr = {16'h0123, b};
        oeN = 1;
        drive(0, 1, 0, 1, 0);
        drv = 1;
        for (int n = 0; n < 4; n++) begin
            if (n < 3) begin
                drive(1, 1, 1, 0, 0);
            end else begin
                drive(1, 1, 0, 1, 1);
            end
            hData = pat(m, b, n[1:0]);
        end
        @(negedge clk);
        drv = 0;
        oeN = 0;
        for (int n = 0; n < 4; n++) begin
            lo = m ? b ^ n[1:0] : b + n[1:0];
            rd({16'h0123, lo}, pat(m, b, n[1:0]));
        end
    endtask
    task automatic waitCycle;
        addr = {16'h0123, 2'h0};
        drive(0, 0, 1, 1, 1);
        drive(1, 1, 1, 1, 1);
        chk(dOut, pat(0, 2'h2, 2'h2));
        drive(1, 1, 1, 0, 1);
        chk(dOut, pat(0, 2'h2, 2'h2));
        drive(1, 1, 0, 1, 1);
        chk(dOut, pat(0, 2'h2, 2'h3));
        oeN = 1;
        #1 chkF(dOe, 4'h0);
        oeN = 0;
        ce2 = 0;
        drive(0, 0, 1, 1, 1);
        drive(1, 1, 0, 1, 1);
        chkF(dOe, 4'h0);
        ce2 = 1;
        ce3N = 1;
        drive(0, 0, 1, 1, 1);
        drive(1, 1, 0, 1, 1);
        chkF(dOe, 4'h0);
        ce3N = 0;
    endtask
    task automatic writes;
        logic [DW-1:0] old;
        old = pat(0, 2'h2, 2'h2);
        addr = {16'h0123, 2'h0};
        oeN = 1;
        bweN = 0;
        laneN = 4'hE;
        drive(0, 1, 0, 1, 1);
        drv = 1;
        hData = '1;
        drive(1, 1, 0, 1, 1);
        @(negedge clk);
        drv = 0;
        bweN = 1;
        laneN = '1;
        oeN = 0;
        rd(addr, {old[DW-1:SBSRAM_LANE_W], 9'h1FF});
        oeN = 1;
        drive(0, 0, 1, 1, 1);
        drv = 1;
        hData = 36'h123456789;
        drive(1, 1, 1, 1, 0);
        drive(1, 1, 0, 1, 1);
        @(negedge clk);
        drv = 0;
        oeN = 0;
        rd(addr, 36'h123456789);
    endtask
    task automatic sleepTest;
        drive(1, 1, 0, 1, 1);
        sleepReq = 1;
        repeat (4) @(negedge clk);
        chkF({3'h0, slp}, 4'h1);
        sleepReq = 0;
        repeat (4) @(negedge clk);
        chkF({3'h0, slp}, 4'h0);
        rd({16'h0123, 2'h1}, pat(0, 2'h2, 2'h3));
    endtask
    initial begin
        repeat (5) @(negedge clk);
        chkF(dOe, 4'h0);
        resetn = 1;
        burstOrder(1, 2'h1);
        burstOrder(0, 2'h2);
        waitCycle;
        writes;
        sleepTest;
        complete_run;
    end
    initial begin
        #100000;
        errorCnt++;
        complete_run;
    end
endmodule
